// ### shared/fifo_defines.svh
`ifndef FIFO_DEFINES_SVH
`define FIFO_DEFINES_SVH

// ****************************************************************
// Widths
// ****************************************************************
`define FIFO_DATA_W        9
`define FIFO_ADDR_W        14
`define FIFO_OFS_W         18
`define FIFO_CMP_W         20

// ****************************************************************
// Offset register selection sequence
// ****************************************************************
`define OFS_SEL_W          2
`define OFS_EMPTY_LOW      2'h0
`define OFS_EMPTY_HIGH     2'h1
`define OFS_FULL_LOW       2'h2
`define OFS_FULL_HIGH      2'h3

// ****************************************************************
// Reset values
// ****************************************************************
`define OFS_LOW_RESET      9'h007
`define OFS_HIGH_RESET     9'h000
`define DATA_OUT_RESET     9'h000

`endif

// ### shared/fifo_pkg.sv
`include "fifo_defines.svh"

package fifo_pkg;

   typedef enum logic {
      mode_prog_flags,
      mode_two_enables
   } fifo_mode_e;

   typedef struct packed {
      logic                       write_enable_first_n;
      logic                       write_enable_second_or_load;
      logic [`FIFO_DATA_W-1:0]    write_data_in;
   } write_pins_s;

   typedef struct packed {
      logic read_enable_first_n;
      logic read_enable_second_n;
      logic output_enable_n;
   } read_pins_s;

   typedef struct packed {
      logic empty_flag_n;
      logic almost_empty_flag_n;
      logic full_flag_n;
      logic almost_full_flag_n;
   } flags_s;

endpackage : fifo_pkg

// ### core/pin_clock_edge.sv
`timescale 1ns/1ps

// Synchronises a pin clock and strobes one cycle per rising edge
module pin_clock_edge
(
   input  wire logic i_clock,
   input  wire logic i_reset,
   input  wire logic i_level,
   output logic      o_rise
);

   logic meta_q;
   logic sync_q;
   logic last_q;

   always_ff @(posedge i_clock)
   begin
      if (i_reset)
      begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         last_q <= 1'b0;
      end
      else
      begin
         meta_q <= i_level;
         sync_q <= meta_q;
         last_q <= sync_q;
      end
   end

   assign o_rise = sync_q & ~last_q;

endmodule : pin_clock_edge

// ### core/dual_clock_fifo_prog_flags.sv
`timescale 1ns/1ps
`include "fifo_defines.svh"

module dual_clock_fifo_prog_flags
#(
   parameter int ADDR_W  = `FIFO_ADDR_W,
   parameter bit CASCADE = 1'b0
)
(
   input  wire logic                    i_clock,
   input  wire logic                    i_reset,
   input  wire logic                    i_write_clock,
   input  wire logic                    i_read_clock,
   input  wire fifo_pkg::write_pins_s   i_write,
   input  wire fifo_pkg::read_pins_s    i_read,
   output logic [`FIFO_DATA_W-1:0]      o_read_data_out,
   output logic                         o_read_data_oe,
   output fifo_pkg::flags_s             o_flags
);

   localparam int PW = ADDR_W + 1;
   localparam int CW = `FIFO_CMP_W;
   localparam logic [CW-1:0] DEPTH = CW'(1) << ADDR_W;

   // ****************************************************************
   // Pin clock edges
   // ****************************************************************
   logic write_edge;
   logic read_edge;

   // Both pin clocks pass two flops before any edge logic looks at them
   pin_clock_edge u_write_edge
   (
      .i_clock (i_clock),
      .i_reset (i_reset),
      .i_level (i_write_clock),
      .o_rise  (write_edge)
   );

   pin_clock_edge u_read_edge
   (
      .i_clock (i_clock),
      .i_reset (i_reset),
      .i_level (i_read_clock),
      .o_rise  (read_edge)
   );

   // ****************************************************************
   // State
   // ****************************************************************
   fifo_pkg::fifo_mode_e           mode_q;
   logic [`FIFO_DATA_W-1:0]        mem_q [0:(1<<ADDR_W)-1];
   logic [`FIFO_DATA_W-1:0]        offset_q [0:3];
   logic [`OFS_SEL_W-1:0]          wsel_q;
   logic [`OFS_SEL_W-1:0]          rsel_q;
   logic [PW-1:0]                  wr_ptr_q;
   logic [PW-1:0]                  rd_ptr_q;
   logic [`FIFO_DATA_W-1:0]        data_q;
   logic                           full_n_q;
   logic                           almost_full_n_q;
   logic                           empty_n_q;
   logic                           almost_empty_n_q;

   // ****************************************************************
   // Decode
   // ****************************************************************
   logic          two_enables;
   logic          load_active;
   logic          write_asked;
   logic          reads_enabled;
   logic          do_write;
   logic          do_ofs_write;
   logic          do_read;
   logic          do_ofs_read;
   logic [PW-1:0] wr_ptr_d;
   logic [PW-1:0] rd_ptr_d;
   logic [PW-1:0] words_wr;
   logic [PW-1:0] words_rd;
   logic [CW-1:0] ofs_n;
   logic [CW-1:0] ofs_m;

   assign two_enables   = (mode_q == fifo_pkg::mode_two_enables);
   assign load_active   = ~two_enables & ~i_write.write_enable_second_or_load;
   assign write_asked   = ~i_write.write_enable_first_n;
   assign reads_enabled = ~i_read.read_enable_first_n & ~i_read.read_enable_second_n;

   // In either mode the second pin must be high for an array write
   assign do_write      = write_edge & write_asked & i_write.write_enable_second_or_load
                          & full_n_q;
   assign do_ofs_write  = write_edge & write_asked & load_active;
   assign do_read       = read_edge & reads_enabled & ~load_active
                          & empty_n_q;
   assign do_ofs_read   = read_edge & reads_enabled & load_active;

   assign wr_ptr_d = wr_ptr_q + PW'(do_write);
   assign rd_ptr_d = rd_ptr_q + PW'(do_read);

   // Each side counts with its own new pointer and the other's current one
   assign words_wr = wr_ptr_d - rd_ptr_q;
   assign words_rd = wr_ptr_q - rd_ptr_d;

   assign ofs_n = CW'({offset_q[`OFS_EMPTY_HIGH], offset_q[`OFS_EMPTY_LOW]});
   assign ofs_m = CW'({offset_q[`OFS_FULL_HIGH], offset_q[`OFS_FULL_LOW]});

   // ****************************************************************
   // Mode strap
   // ****************************************************************
   always_ff @(posedge i_clock)
   begin
      if (i_reset)
      begin
         mode_q <= i_write.write_enable_second_or_load ? fifo_pkg::mode_two_enables
                                                       : fifo_pkg::mode_prog_flags;
      end
   end

   // ****************************************************************
   // Storage array
   // ****************************************************************
   always_ff @(posedge i_clock)
   begin
      if (do_write)
      begin
         mem_q[wr_ptr_q[ADDR_W-1:0]] <= i_write.write_data_in;
      end
   end

   // ****************************************************************
   // Offset registers
   // ****************************************************************
   always_ff @(posedge i_clock)
   begin
      if (i_reset)
      begin
         offset_q[`OFS_EMPTY_LOW]  <= `OFS_LOW_RESET;
         offset_q[`OFS_EMPTY_HIGH] <= `OFS_HIGH_RESET;
         offset_q[`OFS_FULL_LOW]   <= `OFS_LOW_RESET;
         offset_q[`OFS_FULL_HIGH]  <= `OFS_HIGH_RESET;
         wsel_q                    <= `OFS_EMPTY_LOW;
      end
      else if (do_ofs_write)
      begin
         offset_q[wsel_q] <= i_write.write_data_in;
         wsel_q           <= wsel_q + 2'h1;
      end
   end

   // ****************************************************************
   // Write side: pointer and write-clock flags
   // ****************************************************************
   always_ff @(posedge i_clock)
   begin
      if (i_reset)
      begin
         wr_ptr_q                   <= '0;
         full_n_q                   <= 1'b1;
         almost_full_n_q            <= 1'b1;
      end
      else if (write_edge)
      begin
         wr_ptr_q                   <= wr_ptr_d;
         full_n_q                   <= (CW'(words_wr) != DEPTH);
         almost_full_n_q            <= (CW'(words_wr) + ofs_m < DEPTH);
      end
   end

   // ****************************************************************
   // Read side: pointer, output register and read-clock flags
   // ****************************************************************
   always_ff @(posedge i_clock)
   begin
      if (i_reset)
      begin
         rd_ptr_q                    <= '0;
         data_q                      <= `DATA_OUT_RESET;
         rsel_q                      <= `OFS_EMPTY_LOW;
         empty_n_q                   <= 1'b0;
         almost_empty_n_q            <= 1'b0;
      end
      else if (read_edge)
      begin
         rd_ptr_q                    <= rd_ptr_d;
         empty_n_q                   <= (words_rd != '0);
         almost_empty_n_q            <= (CW'(words_rd) > ofs_n);
         if (do_read)
         begin
            data_q <= mem_q[rd_ptr_q[ADDR_W-1:0]];
         end
         else if (do_ofs_read)
         begin
            data_q <= offset_q[rsel_q];
            rsel_q <= rsel_q + 2'h1;
         end
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   logic drive_enable;

   // Cascaded parts only drive while read enabled; the output enable never moves pointers
   assign drive_enable = ~i_read.output_enable_n
                         & (~CASCADE | reads_enabled);

   assign o_read_data_out = data_q;
   assign o_read_data_oe  = drive_enable;
   assign o_flags         = '{empty_n_q, almost_empty_n_q, full_n_q, almost_full_n_q};

endmodule : dual_clock_fifo_prog_flags

// ### testbench/dual_clock_fifo_prog_flags_properties.sv
`timescale 1ns/1ps
`include "fifo_defines.svh"

// ****
// Flag, data and enable timing checks
// ****
module dual_clock_fifo_prog_flags_properties
#(
   parameter int ADDR_W  = `FIFO_ADDR_W,
   parameter bit CASCADE = 1'b0
)
(
   input wire logic                    i_clock,
   input wire logic                    i_reset,
   input wire logic                    i_write_clock,
   input wire logic                    i_read_clock,
   input wire fifo_pkg::write_pins_s   i_write,
   input wire fifo_pkg::read_pins_s    i_read,
   input wire logic [`FIFO_DATA_W-1:0] o_read_data_out,
   input wire logic                    o_read_data_oe,
   input wire fifo_pkg::flags_s        o_flags
);
   logic       wr_prev_q;
   logic       rd_prev_q;
   logic [2:0] wr_age_q;
   logic [2:0] rd_age_q;
   wire        wr_rise = i_write_clock && !wr_prev_q;
   wire        rd_rise = i_read_clock && !rd_prev_q;

   // Cycles since each pin clock last rose, saturating at seven
   always_ff @(posedge i_clock)
   begin
      wr_prev_q <= i_write_clock;
      rd_prev_q <= i_read_clock;
      wr_age_q  <= (i_reset || wr_rise) ? {3{i_reset}} : wr_age_q + {2'h0, wr_age_q != 3'h7};
      rd_age_q  <= (i_reset || rd_rise) ? {3{i_reset}} : rd_age_q + {2'h0, rd_age_q != 3'h7};
   end

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_reset);

   sequence s_rd_recent;
      rd_age_q >= 3'h2 && rd_age_q <= 3'h5;
   endsequence
   sequence s_wr_recent;
      wr_age_q >= 3'h2 && wr_age_q <= 3'h5;
   endsequence
   sequence s_empty_holds;
      $stable(o_flags.empty_flag_n) [*4];
   endsequence

   a_empty_read_edge: assert property (!$past(i_reset) && $changed(o_flags.empty_flag_n)
      |-> s_rd_recent) else $error("empty flag moved off a read edge");
   a_aempty_read_edge: assert property (!$past(i_reset)
      && $changed(o_flags.almost_empty_flag_n) |-> s_rd_recent) else $error("almost empty off edge");
   a_full_write_edge: assert property (!$past(i_reset) && $changed(o_flags.full_flag_n)
      |-> s_wr_recent) else $error("full flag moved off a write edge");
   a_afull_write_edge: assert property (!$past(i_reset)
      && $changed(o_flags.almost_full_flag_n) |-> s_wr_recent) else $error("almost full off edge");
   a_data_read_edge: assert property (!$past(i_reset) && $changed(o_read_data_out)
      |-> s_rd_recent) else $error("output data moved off a read edge");
   a_empty_flag_holds: assert property ($changed(o_flags.empty_flag_n) |=> s_empty_holds)
      else $error("empty flag did not hold");
   a_oe_follows_pin: assert property (o_read_data_oe == (!i_read.output_enable_n
      && (!CASCADE || (!i_read.read_enable_first_n && !i_read.read_enable_second_n))))
      else $error("output enable mismatch");
   a_reset_state: assert property ($past(i_reset) |-> o_flags == 4'h3
      && o_read_data_out == 9'h000) else $error("state after reset wrong");
endmodule : dual_clock_fifo_prog_flags_properties

bind dual_clock_fifo_prog_flags dual_clock_fifo_prog_flags_properties
   #(.ADDR_W(ADDR_W), .CASCADE(CASCADE)) u_properties
   (.i_clock(i_clock), .i_reset(i_reset), .i_write_clock(i_write_clock),
    .i_read_clock(i_read_clock), .i_write(i_write), .i_read(i_read),
    .o_read_data_out(o_read_data_out), .o_read_data_oe(o_read_data_oe), .o_flags(o_flags));

// ### testbench/pin_side_model.sv
`timescale 1ns/1ps

// ****
// Writer and reader logic, each with its own pin clock
// ****
module pin_side_model
(
   input  wire logic             i_clock,
   output logic                  o_write_clock,
   output logic                  o_read_clock,
   output fifo_pkg::write_pins_s o_write,
   output fifo_pkg::read_pins_s  o_read
);
   initial
   begin
      o_write_clock = 1'b0;
      o_read_clock  = 1'b0;
      o_write       = '{1'b1, 1'b1, 9'h000};
      o_read        = '{1'b1, 1'b1, 1'b0};
   end

   // One pin clock at a time, so offset writes and reads never overlap
   task automatic pulse(input bit rd);
      repeat (3) @(negedge i_clock);
      {o_read_clock, o_write_clock} = {rd, !rd};
      repeat (4) @(negedge i_clock);
      {o_read_clock, o_write_clock} = 2'b00;
      repeat (4) @(negedge i_clock);
   endtask : pulse

   task automatic set_pins(input logic ld, input logic oe_n);
      @(negedge i_clock);
      o_write.write_enable_second_or_load = ld;
      o_read.output_enable_n              = oe_n;
   endtask : set_pins

   task automatic write_word(input logic en_n, input logic ld, input logic [8:0] d);
      @(negedge i_clock);
      o_write = '{en_n, ld, d};
      pulse(1'b0);
   endtask : write_word

   task automatic read_word(input logic en_n, input logic ld);
      @(negedge i_clock);
      o_read.read_enable_first_n          = en_n;
      o_read.read_enable_second_n         = en_n;
      o_write.write_enable_second_or_load = ld;
      pulse(1'b1);
   endtask : read_word
endmodule : pin_side_model

// ### testbench/dual_clock_fifo_prog_flags_tb_top.sv
`timescale 1ns/1ps

module dual_clock_fifo_prog_flags_tb_top;
   localparam int DEPTH = 16;
   logic                  i_clock;
   logic                  i_reset;
   logic                  write_clock;
   logic                  read_clock;
   fifo_pkg::write_pins_s write_pins;
   fifo_pkg::read_pins_s  read_pins;
   logic [8:0]            read_data;
   logic                  read_oe;
   logic                  cascade_oe;
   fifo_pkg::flags_s      flags;
   int                    mismatches;
   int                    checks_done;

   pin_side_model model (.i_clock(i_clock), .o_write_clock(write_clock),
      .o_read_clock(read_clock), .o_write(write_pins), .o_read(read_pins));
   dual_clock_fifo_prog_flags #(.ADDR_W(4), .CASCADE(1'b0)) DUT (.i_clock(i_clock),
      .i_reset(i_reset), .i_write_clock(write_clock), .i_read_clock(read_clock),
      .i_write(write_pins), .i_read(read_pins), .o_read_data_out(read_data),
      .o_read_data_oe(read_oe), .o_flags(flags));
   dual_clock_fifo_prog_flags #(.ADDR_W(4), .CASCADE(1'b1)) cascade_dut (.i_clock(i_clock),
      .i_reset(i_reset), .i_write_clock(write_clock), .i_read_clock(read_clock),
      .i_write(write_pins), .i_read(read_pins), .o_read_data_out(),
      .o_read_data_oe(cascade_oe), .o_flags());

   initial
   begin
      i_clock = 1'b0;
      forever #20 i_clock = ~i_clock;
   end

   task automatic compare(input string name, input logic [8:0] exp, input logic [8:0] got);
      checks_done++;
      if (got !== exp)
      begin
         $display("unexpected %s: expected %h seen %h", name, exp, got);
         mismatches++;
      end
   endtask : compare

   task automatic wrap_up;
      if (mismatches == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : wrap_up

   // No pin clock runs while reset is held
   task automatic do_reset(input logic ld);
      i_reset = 1'b1;
      model.set_pins(ld, 1'b0);
      repeat (5) @(negedge i_clock);
      i_reset = 1'b0;
      @(negedge i_clock);
      compare("reset flags", 9'h003, {5'h00, flags});
      compare("reset data", 9'h000, read_data);
   endtask : do_reset

   task automatic fill(input int count, input int m, input logic [8:0] base);
      int k;
      for (int i = 1; i <= count; i++)
      begin
         model.write_word(1'b0, 1'b1, base + 9'(i - 1));
         k = (i < DEPTH) ? i : DEPTH;
         compare("fill flags", {7'h00, k < DEPTH, k + m < DEPTH}, {5'h00, flags});
      end
   endtask : fill

   task automatic drain(input int count, input int n, input logic [8:0] base);
      model.read_word(1'b1, 1'b1);
      compare("empty flags", {7'h00, 1'b1, count > n}, {7'h00, flags[3:2]});
      compare("cascade enable", 9'h000, {8'h00, cascade_oe});
      for (int i = 0; i <= count; i++)
      begin
         model.read_word(1'b0, 1'b1);
         compare("read data", base + 9'((i < count) ? i : count - 1), read_data);
         compare("drain flags", {7'h00, count - 1 > i, count - 1 - i > n},
            {7'h00, flags[3:2]});
      end
   endtask : drain

   initial
   begin
      logic [8:0] ofs [5];
      ofs         = '{9'h002, 9'h000, 9'h005, 9'h000, 9'h003};
      i_reset     = 1'b1;
      mismatches  = 0;
      checks_done = 0;
      do_reset(1'b1);
      model.write_word(1'b0, 1'b0, 9'h1ff);
      fill(DEPTH + 1, 7, 9'h100);
      drain(DEPTH, 7, 9'h100);
      model.set_pins(1'b1, 1'b1);
      @(negedge i_clock);
      compare("output enable", 9'h000, {8'h00, read_oe});
      compare("cascade enable", 9'h000, {8'h00, cascade_oe});
      model.set_pins(1'b1, 1'b0);
      @(negedge i_clock);
      compare("output enable", 9'h001, {8'h00, read_oe});
      compare("cascade enable", 9'h001, {8'h00, cascade_oe});
      do_reset(1'b0);
      // Load goes high mid-sequence; the next load write must continue the order
      foreach (ofs[i])
      begin
         if (i == 2)
         begin
            model.write_word(1'b1, 1'b1, 9'h1aa);
         end
         model.write_word(1'b0, 1'b0, ofs[i]);
      end
      for (int i = 0; i < 5; i++)
      begin
         model.read_word(1'b0, 1'b0);
         compare("offset", ofs[(i + 1) % 4 == 1 ? 4 : i], read_data);
      end
      model.write_word(1'b1, 1'b1, 9'h1aa);
      fill(DEPTH + 1, 5, 9'h040);
      drain(DEPTH, 3, 9'h040);
      wrap_up();
   end

   initial
   begin
      repeat (20000) @(posedge i_clock);
      mismatches++;
      wrap_up();
   end
endmodule : dual_clock_fifo_prog_flags_tb_top
